/* include/orp_pkg.sv */
`default_nettype none
package orp_pkg;

	// setpoint increment in microvolts and the slope table in microvolts per microsecond
	localparam int STEP_UV = 12500;
	localparam int RATE_0_UV_US = 100;
	localparam int RATE_1_UV_US = 200;
	localparam int RATE_2_UV_US = 500;
	localparam int RATE_3_UV_US = 750;
	localparam int RATE_4_UV_US = 1000;
	localparam int RATE_5_UV_US = 2000;
	localparam int RATE_6_UV_US = 5000;
	localparam int RATE_7_UV_US = 8300;

	// nominal frequency of the master clock from the power manager
	localparam int MCLK_KHZ = 4000;

	// clock of this block, 10 MHz
	localparam int CLK_KHZ = 10000;

	// tracking configuration field layout
	localparam int CFG_RISE_LSB = 4;
	localparam int CFG_SLEW_BIT = 3;
	localparam int CFG_FALL_LSB = 0;
	localparam int CFG_SPARE_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h08;
	localparam logic [7:0] CFG_WMASK = 8'h7F;

	// status flag positions, a flag reads zero while its condition is active
	localparam int FLG_TEMP_WARN = 7;
	localparam int FLG_OUT_GOOD = 6;
	localparam int FLG_TRACK = 5;
	localparam int FLG_OVER_TEMP = 4;
	localparam int FLG_OVER_CUR = 3;
	localparam int FLG_UNDER_V = 2;
	localparam int FLG_OVER_V = 1;
	localparam int FLG_PHASE_V = 0;
	localparam logic [7:0] FLAGS_RESET = 8'hBF;

	localparam int SP_W = 9;
	localparam int CNT_W = 10;

	typedef logic [SP_W-1:0] orp_sp_t;
	typedef logic [CNT_W-1:0] orp_cnt_t;

	// master clock edges per setpoint increment for one 3-bit rate code
	function automatic orp_cnt_t orp_step_count(input logic [2:0] code);
		int rate;
		int step_ns;
		int cnt;
		unique case (code)
			3'h0: rate = RATE_0_UV_US;
			3'h1: rate = RATE_1_UV_US;
			3'h2: rate = RATE_2_UV_US;
			3'h3: rate = RATE_3_UV_US;
			3'h4: rate = RATE_4_UV_US;
			3'h5: rate = RATE_5_UV_US;
			3'h6: rate = RATE_6_UV_US;
			3'h7: rate = RATE_7_UV_US;
		endcase
		step_ns = (STEP_UV * 1000) / rate;
		cnt = (step_ns * MCLK_KHZ) / 1000000;
		if (cnt < 1) begin
			cnt = 1;
		end
		return cnt[CNT_W-1:0];
	endfunction

endpackage
`default_nettype wire

/* include/orp_step_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the step period request and the step pulse back
interface orp_step_if;
	import orp_pkg::*;
	logic run;
	orp_cnt_t period;
	logic step;
	modport ctl (output run, output period, input step);
	modport tmr (input run, input period, output step);
endinterface
`default_nettype wire

/* rtl/orp_step_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module orp_step_timer
	import orp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic master_clk,
	orp_step_if.tmr stp
);

	typedef struct packed {
		logic mclk_prev;
		orp_cnt_t cnt;
		logic step;
	} orp_tmr_st_t;

	orp_tmr_st_t st_r;
	orp_tmr_st_t st_nxt;
	logic mclk_edge;

	// rising edges of the shared master clock are the only time base
	assign mclk_edge = master_clk & ~st_r.mclk_prev;
	assign stp.step = st_r.step;

	// divide master clock edges down to one step per period
	always_comb begin
		st_nxt = st_r;
		st_nxt.mclk_prev = master_clk;
		st_nxt.step = 1'b0;
		if (!stp.run) begin
			st_nxt.cnt = '0;
		end else if (mclk_edge) begin
			if (st_r.cnt + 1'b1 >= stp.period) begin
				st_nxt.cnt = '0;
				st_nxt.step = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

/* rtl/orp_prot_status.sv */
`timescale 1ns/1ps
`default_nettype none
module orp_prot_status
	import orp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] cond_active,
	input wire logic ramp_up_active,
	output logic [7:0] flags
);

	typedef struct packed {
		logic [7:0] flags;
	} orp_sts_st_t;

	orp_sts_st_t st_r;
	orp_sts_st_t st_nxt;

	assign flags = st_r.flags;

	// every flag mirrors its condition inverted, active reads zero
	always_comb begin
		st_nxt = st_r;
		st_nxt.flags = ~cond_active;
		// overcurrent trips on the ramp as anywhere else, charge current included
		if (ramp_up_active && cond_active[FLG_OVER_CUR]) begin
			st_nxt.flags[FLG_OVER_CUR] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r.flags <= FLAGS_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

/* rtl/orp_ramp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module orp_ramp_top
	import orp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic master_clk,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] ramp_tracking_config,
	output logic [7:0] protection_flags,
	input wire logic [7:0] cond_active,
	input wire logic turn_on,
	input wire logic [SP_W-1:0] target_code,
	output logic [SP_W-1:0] setpoint,
	output logic ramp_active,
	output logic ramp_done
);

	typedef enum logic [2:0] {
		ORP_IDLE = 3'h1,
		ORP_UP = 3'h2,
		ORP_DOWN = 3'h4
	} orp_state_t;

	typedef struct packed {
		orp_state_t state;
		logic [7:0] cfg;
		orp_sp_t sp;
		logic done;
	} orp_top_st_t;

	orp_top_st_t st_r;
	orp_top_st_t st_nxt;
	orp_sp_t goal;
	logic slew_en;
	logic [2:0] rise_code;
	logic [2:0] fall_code;
	orp_sp_t sp_step;

	orp_step_if stp ();

	orp_step_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.master_clk(master_clk),
		.stp(stp)
	);

	orp_prot_status u_status (
		.clk(clk),
		.rst_b(rst_b),
		.cond_active(cond_active),
		.ramp_up_active(st_r.state == ORP_UP),
		.flags(protection_flags)
	);

	// configuration fields
	assign rise_code = st_r.cfg[CFG_RISE_LSB +: 3];
	assign fall_code = st_r.cfg[CFG_FALL_LSB +: 3];
	assign slew_en = st_r.cfg[CFG_SLEW_BIT];
	assign goal = turn_on ? target_code : '0;

	// step period follows the direction of travel
	assign stp.run = (st_r.state != ORP_IDLE);
	assign stp.period = (st_r.state == ORP_DOWN) ? orp_step_count(fall_code)
		: orp_step_count(rise_code);

	// outputs
	assign ramp_tracking_config = st_r.cfg & CFG_WMASK;
	assign setpoint = st_r.sp;
	assign ramp_active = stp.run;
	assign ramp_done = st_r.done;

	// one increment toward the goal
	always_comb begin
		if (st_r.sp < goal) begin
			sp_step = st_r.sp + 1'b1;
		end else if (st_r.sp > goal) begin
			sp_step = st_r.sp - 1'b1;
		end else begin
			sp_step = st_r.sp;
		end
	end

	// config write and ramp sequencing
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (cfg_wr_en) begin
			st_nxt.cfg = cfg_wdata & CFG_WMASK;
		end
		unique case (st_r.state)
			ORP_IDLE: begin
				if (st_r.sp != goal) begin
					if (!slew_en) begin
						st_nxt.sp = goal;
						st_nxt.done = 1'b1;
					end else if (st_r.sp < goal) begin
						st_nxt.state = ORP_UP;
					end else begin
						st_nxt.state = ORP_DOWN;
					end
				end
			end
			ORP_UP, ORP_DOWN: begin
				if (!slew_en) begin
					st_nxt.sp = goal;
					st_nxt.state = ORP_IDLE;
					st_nxt.done = 1'b1;
				end else if (st_r.sp == goal) begin
					st_nxt.state = ORP_IDLE;
					st_nxt.done = 1'b1;
				end else if ((st_r.state == ORP_UP) != (st_r.sp < goal)) begin
					// goal moved across the setpoint, restart in the other direction
					st_nxt.state = (st_r.sp < goal) ? ORP_UP : ORP_DOWN;
				end else if (stp.step) begin
					st_nxt.sp = sp_step;
					if (sp_step == goal) begin
						st_nxt.state = ORP_IDLE;
						st_nxt.done = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r.state <= ORP_IDLE;
			st_r.cfg <= CFG_RESET;
			st_r.sp <= '0;
			st_r.done <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

/* verif/orp_mclk_model.sv */
`timescale 1ns/1ps
`default_nettype none
// shared master clock of the power manager
module orp_mclk_model #(
	parameter realtime HALF_NS = 125.0,
	parameter realtime LAG_NS = 20.0
) (
	output logic master_clk
);
	// one common clock fed to every converter, runs free
	initial begin
		master_clk = 1'b0;
		// keep every toggle off the clk edge grid so sampling never races
		#(LAG_NS);
		forever #(HALF_NS) master_clk = ~master_clk;
	end
endmodule
`default_nettype wire

/* verif/orp_ramp_props.sv */
`timescale 1ns/1ps
`default_nettype none
module orp_ramp_props
	import orp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic master_clk,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] ramp_tracking_config,
	input wire logic [7:0] protection_flags,
	input wire logic [7:0] cond_active,
	input wire logic turn_on,
	input wire logic [SP_W-1:0] target_code,
	input wire logic [SP_W-1:0] setpoint,
	input wire logic ramp_active,
	input wire logic ramp_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	localparam int N_TAB [8] = '{500, 250, 100, 66, 50, 25, 10, 6};
	logic mclk_q;
	logic [SP_W-1:0] sp_q;
	logic [SP_W-1:0] goal;
	logic [2:0] code;
	int edges;
	// master rising edges seen since the last setpoint move
	always_ff @(posedge clk) begin
		mclk_q <= master_clk;
		sp_q <= setpoint;
		if (!rst_b || !ramp_active) begin
			edges <= 0;
		end else if (setpoint != sp_q) begin
			// divider restarted a cycle before the move showed, keep an edge seen now
			edges <= (master_clk && !mclk_q) ? 1 : 0;
		end else if (master_clk && !mclk_q) begin
			edges <= edges + 1;
		end
	end
	// goal and the rate code of the current direction
	always_comb begin
		goal = turn_on ? target_code : '0;
		code = (setpoint > sp_q) ? ramp_tracking_config[6:4] : ramp_tracking_config[2:0];
	end
	sequence s_slew_step;
		$past(rst_b) && $past(ramp_active) && ramp_tracking_config[3]
			&& $past(ramp_tracking_config[3]) && setpoint != sp_q;
	endsequence
	sequence s_idle_req;
		!ramp_active && setpoint != goal;
	endsequence
	chk_cfg_spare: assert property (ramp_tracking_config[7] == 1'b0)
		else $error("config spare bit set");
	chk_cfg_write: assert property (cfg_wr_en |=> ramp_tracking_config == ($past(cfg_wdata) & 8'h7F))
		else $error("config write lost");
	chk_reset_vals: assert property (disable iff (1'b0) !rst_b |=> ramp_tracking_config == 8'h08 && protection_flags == 8'hBF)
		else $error("reset values wrong");
	chk_flag_track: assert property ($past(rst_b) |-> protection_flags == ~$past(cond_active))
		else $error("flags do not follow conditions");
	chk_done_pulse: assert property (ramp_done |=> !ramp_done)
		else $error("done longer than one cycle");
	chk_step_size: assert property (s_slew_step |-> setpoint == sp_q + 1'b1 || setpoint + 1'b1 == sp_q)
		else $error("setpoint step not one unit");
	chk_step_time: assert property (s_slew_step |-> edges == N_TAB[code])
		else $error("step not divided from master clock");
	chk_slew_bypass: assert property (s_idle_req ##0 !ramp_tracking_config[3] |=> setpoint == $past(goal) && ramp_done)
		else $error("uncontrolled ramp not immediate");
	chk_ramp_start: assert property (s_idle_req ##0 ramp_tracking_config[3] |=> ramp_active)
		else $error("ramp did not start");
	chk_done_goal: assert property (ramp_done |-> setpoint == goal && !ramp_active)
		else $error("done away from goal");
endmodule
`default_nettype wire

/* verif/orp_ramp_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module orp_ramp_top_test;
	import orp_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic master_clk;
	logic cfg_wr_en = 1'b0;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] ramp_tracking_config;
	logic [7:0] protection_flags;
	logic [7:0] cond_active = 8'h00;
	logic turn_on = 1'b0;
	logic [SP_W-1:0] target_code = 9'h001;
	logic [SP_W-1:0] setpoint;
	logic ramp_active;
	logic ramp_done;
	int mismatches = 0;
	int comparisons = 0;
	int rates [8] = '{100, 200, 500, 750, 1000, 2000, 5000, 8300};
	always #50 clk = ~clk;
	orp_mclk_model mgr (.master_clk(master_clk));
	orp_ramp_top dut (.clk, .rst_b, .master_clk, .cfg_wr_en, .cfg_wdata, .ramp_tracking_config,
		.protection_flags, .cond_active, .turn_on, .target_code, .setpoint, .ramp_active, .ramp_done);
	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one-cycle config write strobe
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		cfg_wr_en <= 1'b1;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr_en <= 1'b0;
	endtask
	// set the goal, time the ramp until done
	task automatic ramp(input logic on, input int exp_cyc);
		int cyc;
		cyc = 0;
		@(posedge clk);
		turn_on <= on;
		do begin
			@(posedge clk);
			#1;
			cyc++;
		end while (ramp_done !== 1'b1 && cyc < 3000);
		if (ramp_done !== 1'b1) begin
			mismatches++;
			$display("MISMATCH t=%0t ramp never finished", $time);
			final_report();
		end
		check(setpoint, on ? target_code : 9'h000, "setpoint");
		check(ramp_active, 1'b0, "ramp still active");
		check(cyc > exp_cyc - 5 && cyc < exp_cyc + 5, 1'b1, "ramp time");
	endtask
	initial begin
		logic [7:0] e;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		check(ramp_tracking_config, 8'h08, "cfg reset");
		check(protection_flags, 8'hBF, "flag reset");
		wr(8'hFF);
		#1;
		check(ramp_tracking_config, 8'h7F, "cfg spare");
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			cond_active <= 8'h01 << i;
			repeat (2) @(posedge clk);
			#1;
			e = ~(8'h01 << i);
			check(protection_flags, e, "flags");
		end
		@(posedge clk);
		cond_active <= 8'h00;
		$display("test flags done");
		for (int c = 0; c < 8; c++) begin
			wr({1'b0, c[2:0], 1'b1, c[2:0]});
			ramp(1'b1, 12500000 / rates[c] / 100 + 3);
			ramp(1'b0, 12500000 / rates[c] / 100 + 3);
			$display("test rate code %0d done", c);
		end
		wr(8'h00);
		ramp(1'b1, 2);
		ramp(1'b0, 2);
		$display("test uncontrolled ramp done");
		@(posedge clk);
		target_code <= 9'h003;
		cond_active <= 8'h08;
		wr(8'h7F);
		ramp(1'b1, 48);
		check(protection_flags, 8'hF7, "overcurrent flag");
		ramp(1'b0, 48);
		$display("test multi-step ramp done");
		final_report();
	end
endmodule
bind orp_ramp_top orp_ramp_props chk (.clk, .rst_b, .master_clk, .cfg_wr_en, .cfg_wdata,
	.ramp_tracking_config, .protection_flags, .cond_active, .turn_on, .target_code, .setpoint,
	.ramp_active, .ramp_done);
`default_nettype wire
